// File: rtl/sensor_control_port_standby.sv
`include "sensor_ctl_params.svh"

// Behaviour
// - Sub-address pointer advances by one after every byte read or written.
// - Device answers to the common ID held in a writable register, reset 0x42.
// - Select pin low uses selectable ID register (0x6C); high uses common ID.
// - All three ID registers are rewritable; new selectable and common ID values govern later matching, the spare ID never.
// - Message is 7-bit target address, 16-bit sub-address, then 8-bit data.
// - Address byte carries direction in its lowest bit, 0x6C write, 0x6D read.
// - Random read: sub-address write, repeated start, read address, device drives data.
// - A read without sub-address write returns data at the last used pointer.
// - Host acknowledge of a read byte continues with the next sub-address.
// - Writes: address, sub-address, data bytes acknowledged; data goes to rising addresses.
// - Clearing stream bit enters software standby keeping all register contents.
// - After power-on reset the device sits in software standby, bus usable.
// - Shutdown pin low is hardware standby: defaults restored, bus ignored.
// - Whole-chip reset while shutdown is low or core supply is not stable.
// - First frame start within 0.2 ms lock plus 10 ms fixed plus exposure lines after streaming.
// - Each clock synthesizer reaches lock within 0.2 ms of being enabled; here one shared count locks both, running only while neither is held in reset.
// - Standby during a frame waits for frame end; otherwise it is immediate.
module sensor_control_port_standby #(
  parameter int unsigned LOCK_CYC  = `SYNTH_LOCK_CYC,
  parameter int unsigned FIXED_CYC = `FIRST_FRAME_FIXED_CYC,
  parameter int unsigned LINE_CYC  = `LINE_CYC_DEFAULT
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      shutdown_pin_n_i,
  input  wire logic                      core_supply_good_i,
  input  wire logic                      bus_id_select_pin_i,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_n_o,
  input  wire logic                      frame_active_i,
  input  wire logic [15:0]               exposure_lines_i,
  output sensor_ctl_pkg::pwr_status_t    status_o,
  output logic [167:0]                   synth_cfg_o
);

  localparam int NREG = `REG_COUNT;
  localparam int I_MODE = 0;
  localparam int I_MAIN_RST = 20;
  localparam int I_AUX_RST = 21;
  localparam int I_SEL_ID = 22;
  localparam int I_COM_ID = 23;

  localparam logic [15:0] OFFS [NREG] = '{
    `ADDR_STREAM_MODE, `ADDR_MAIN_INPUT_DIV, `ADDR_MAIN_MULT_HIGH, `ADDR_MAIN_MULT_LOW,
    `ADDR_MAIN_M_DIV, `ADDR_MAIN_SERIAL_DIV, `ADDR_MAIN_SP_DIV, `ADDR_MAIN_S_DIV,
    `ADDR_MAIN_BYPASS, `ADDR_MAIN_CHARGE_PUMP, `ADDR_MAIN_PREDIV_ZERO,
    `ADDR_AUX_INPUT_DIV, `ADDR_AUX_MULT_HIGH, `ADDR_AUX_MULT_LOW, `ADDR_AUX_SYS_DIV,
    `ADDR_AUX_SYS_PREDIV, `ADDR_AUX_CHARGE_PUMP, `ADDR_AUX_PREDIV_ZERO,
    `ADDR_AUX_BYP_DAC_DIV, `ADDR_AUX_MEM_DIV, `ADDR_MAIN_SYNTH_RESET,
    `ADDR_AUX_SYNTH_RESET, `ADDR_SELECTABLE_ID, `ADDR_COMMON_ID, `ADDR_SPARE_ID
  };

  localparam logic [7:0] RSTV [NREG] = '{
    `RST_STREAM_MODE, `RST_ZERO, `RST_ZERO, `RST_MAIN_MULT_LOW,
    `RST_ZERO, `RST_MAIN_SERIAL_DIV, `RST_ONE, `RST_ONE,
    `RST_ZERO, `RST_ONE, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_AUX_MULT_LOW, `RST_AUX_SYS_DIV,
    `RST_THREE, `RST_ONE, `RST_ZERO,
    `RST_THREE, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_SELECTABLE_ID, `RST_COMMON_ID, `RST_SPARE_ID
  };

  // Pin synchronisers; stage 0 is read only by stage 1.
  logic [2:0]  scl_q_r;
  logic [2:0]  sda_q_r;
  logic [1:0]  shut_q_r;
  logic [1:0]  supply_q_r;
  logic [1:0]  sel_q_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q_r    <= 3'h7;
      sda_q_r    <= 3'h7;
      shut_q_r   <= 2'h0;
      supply_q_r <= 2'h0;
      sel_q_r    <= 2'h0;
    end else begin
      scl_q_r    <= {scl_q_r[1:0], scl_i};
      sda_q_r    <= {sda_q_r[1:0], sda_i};
      shut_q_r   <= {shut_q_r[0], shutdown_pin_n_i};
      supply_q_r <= {supply_q_r[0], core_supply_good_i};
      sel_q_r    <= {sel_q_r[0], bus_id_select_pin_i};
    end
  end

  logic chip_rst;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign chip_rst  = !shut_q_r[1] || !supply_q_r[1];
  assign scl_rise  = scl_q_r[1] && !scl_q_r[2];
  assign scl_fall  = !scl_q_r[1] && scl_q_r[2];
  assign bus_start = scl_q_r[1] && scl_q_r[2] && !sda_q_r[1] && sda_q_r[2];
  assign bus_stop  = scl_q_r[1] && scl_q_r[2] && sda_q_r[1] && !sda_q_r[2];

  // Register file.
  logic [7:0]  regs_r [NREG];
  logic        wr_en_r;
  logic [15:0] wr_addr_r;
  logic [7:0]  wr_data_r;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs_r[gi] <= RSTV[gi];
        end else if (chip_rst) begin
          regs_r[gi] <= RSTV[gi];
        end else if (wr_en_r && wr_addr_r == OFFS[gi]) begin
          regs_r[gi] <= wr_data_r;
        end
      end
    end
  endgenerate

  logic [15:0] ptr_r;
  logic [7:0]  rd_data;

  // Unmapped sub-addresses read as zero and swallow writes.
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (ptr_r == OFFS[i]) begin
        rd_data = regs_r[i];
      end
    end
  end

  logic [7:0] active_id;
  logic [7:0] shift_r;
  logic       addr_match;

  // Only the upper seven bits identify the target; bit 0 is the direction.
  assign active_id  = sel_q_r[1] ? regs_r[I_COM_ID] : regs_r[I_SEL_ID];
  assign addr_match = (shift_r[7:1] == regs_r[I_COM_ID][7:1]) ||
                      (shift_r[7:1] == active_id[7:1]);

  // Serial target.
  sensor_ctl_pkg::bus_state_t bst_r;
  logic [3:0] bit_r;
  logic [1:0] phase_r;
  logic       rd_mode_r;
  logic       more_r;
  logic       sda_oe_n_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bst_r      <= sensor_ctl_pkg::BUS_IDLE;
      bit_r      <= 4'h0;
      phase_r    <= 2'h0;
      rd_mode_r  <= 1'b0;
      more_r     <= 1'b0;
      shift_r    <= 8'h00;
      ptr_r      <= 16'h0000;
      sda_oe_n_r <= 1'b1;
      wr_en_r    <= 1'b0;
      wr_addr_r  <= 16'h0000;
      wr_data_r  <= 8'h00;
    end else if (chip_rst) begin
      bst_r      <= sensor_ctl_pkg::BUS_IDLE;
      bit_r      <= 4'h0;
      phase_r    <= 2'h0;
      ptr_r      <= 16'h0000;
      sda_oe_n_r <= 1'b1;
      wr_en_r    <= 1'b0;
    end else begin
      wr_en_r <= 1'b0;
      if (bus_start) begin
        // A repeated start keeps the pointer, so current-location reads work.
        bst_r      <= sensor_ctl_pkg::BUS_RX;
        bit_r      <= 4'h0;
        phase_r    <= 2'h0;
        sda_oe_n_r <= 1'b1;
      end else if (bus_stop) begin
        bst_r      <= sensor_ctl_pkg::BUS_IDLE;
        sda_oe_n_r <= 1'b1;
      end else begin
        case (bst_r)
          sensor_ctl_pkg::BUS_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_q_r[1]};
              bit_r   <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              case (phase_r)
                2'h0: begin
                  if (addr_match) begin
                    rd_mode_r  <= shift_r[0];
                    phase_r    <= 2'h1;
                    sda_oe_n_r <= 1'b0;
                    bst_r      <= sensor_ctl_pkg::BUS_RX_ACK;
                  end else begin
                    bst_r <= sensor_ctl_pkg::BUS_IDLE;
                  end
                end
                2'h1: begin
                  ptr_r[15:8] <= shift_r;
                  phase_r     <= 2'h2;
                  sda_oe_n_r  <= 1'b0;
                  bst_r       <= sensor_ctl_pkg::BUS_RX_ACK;
                end
                2'h2: begin
                  ptr_r[7:0] <= shift_r;
                  phase_r    <= 2'h3;
                  sda_oe_n_r <= 1'b0;
                  bst_r      <= sensor_ctl_pkg::BUS_RX_ACK;
                end
                default: begin
                  wr_en_r    <= 1'b1;
                  wr_addr_r  <= ptr_r;
                  wr_data_r  <= shift_r;
                  ptr_r      <= ptr_r + 16'h0001;
                  sda_oe_n_r <= 1'b0;
                  bst_r      <= sensor_ctl_pkg::BUS_RX_ACK;
                end
              endcase
            end
          end
          sensor_ctl_pkg::BUS_RX_ACK: begin
            if (scl_fall) begin
              if (rd_mode_r && phase_r == 2'h1) begin
                sda_oe_n_r <= rd_data[7];
                shift_r    <= {rd_data[6:0], 1'b0};
                ptr_r      <= ptr_r + 16'h0001;
                bit_r      <= 4'h1;
                bst_r      <= sensor_ctl_pkg::BUS_TX;
              end else begin
                sda_oe_n_r <= 1'b1;
                bst_r      <= sensor_ctl_pkg::BUS_RX;
              end
            end
          end
          sensor_ctl_pkg::BUS_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe_n_r <= 1'b1;
                bst_r      <= sensor_ctl_pkg::BUS_TX_ACK;
              end else begin
                sda_oe_n_r <= shift_r[7];
                shift_r    <= {shift_r[6:0], 1'b0};
                bit_r      <= bit_r + 4'h1;
              end
            end
          end
          sensor_ctl_pkg::BUS_TX_ACK: begin
            if (scl_rise) begin
              more_r <= !sda_q_r[1];
            end else if (scl_fall) begin
              if (more_r) begin
                sda_oe_n_r <= rd_data[7];
                shift_r    <= {rd_data[6:0], 1'b0};
                ptr_r      <= ptr_r + 16'h0001;
                bit_r      <= 4'h1;
                bst_r      <= sensor_ctl_pkg::BUS_TX;
              end else begin
                // Negative acknowledge: stay off the line until the stop.
                bst_r <= sensor_ctl_pkg::BUS_IDLE;
              end
            end
          end
          default: begin
            bst_r <= bst_r;
          end
        endcase
      end
    end
  end

  // The pad is open drain, so the driven level is always low.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= sda_oe_n_r;
    end
  end

  // Power sequencing.
  sensor_ctl_pkg::pwr_state_t pst_r;
  logic [23:0] cnt_r;
  logic [15:0] lines_r;
  logic        stream_bit;
  logic        synth_hold;
  logic        first_frame_r;

  assign stream_bit = regs_r[I_MODE][`STREAM_BIT];
  assign synth_hold = regs_r[I_MAIN_RST][`SYNTH_RESET_BIT] ||
                      regs_r[I_AUX_RST][`SYNTH_RESET_BIT];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pst_r         <= sensor_ctl_pkg::PWR_SLEEP;
      cnt_r         <= 24'h000000;
      lines_r       <= 16'h0000;
      first_frame_r <= 1'b0;
    end else if (chip_rst) begin
      pst_r         <= sensor_ctl_pkg::PWR_SLEEP;
      first_frame_r <= 1'b0;
    end else begin
      first_frame_r <= 1'b0;
      case (pst_r)
        sensor_ctl_pkg::PWR_SLEEP: begin
          cnt_r <= 24'h000000;
          if (stream_bit) begin
            pst_r <= sensor_ctl_pkg::PWR_LOCK;
          end
        end
        sensor_ctl_pkg::PWR_LOCK: begin
          if (!stream_bit) begin
            pst_r <= sensor_ctl_pkg::PWR_SLEEP;
          end else if (synth_hold) begin
            cnt_r <= 24'h000000;
          end else if (cnt_r == 24'(LOCK_CYC - 1)) begin
            cnt_r <= 24'h000000;
            pst_r <= sensor_ctl_pkg::PWR_FIXED;
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
        sensor_ctl_pkg::PWR_FIXED: begin
          if (!stream_bit) begin
            pst_r <= sensor_ctl_pkg::PWR_SLEEP;
          end else if (cnt_r == 24'(FIXED_CYC - 1)) begin
            cnt_r   <= 24'h000000;
            lines_r <= 16'h0000;
            pst_r   <= sensor_ctl_pkg::PWR_EXPO;
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
        sensor_ctl_pkg::PWR_EXPO: begin
          if (!stream_bit) begin
            pst_r <= sensor_ctl_pkg::PWR_SLEEP;
          end else if (lines_r >= exposure_lines_i) begin
            first_frame_r <= 1'b1;
            pst_r         <= sensor_ctl_pkg::PWR_STREAM;
          end else if (cnt_r == 24'(LINE_CYC - 1)) begin
            cnt_r   <= 24'h000000;
            lines_r <= lines_r + 16'h0001;
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
        sensor_ctl_pkg::PWR_STREAM: begin
          if (!stream_bit) begin
            pst_r <= frame_active_i ? sensor_ctl_pkg::PWR_DRAIN
                                    : sensor_ctl_pkg::PWR_SLEEP;
          end
        end
        sensor_ctl_pkg::PWR_DRAIN: begin
          if (!frame_active_i) begin
            pst_r <= sensor_ctl_pkg::PWR_SLEEP;
          end
        end
        default: begin
          pst_r <= sensor_ctl_pkg::PWR_SLEEP;
        end
      endcase
    end
  end

  // Status flags are registered so the outputs come straight from flops.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '{standby: 1'b1, default: 1'b0};
    end else begin
      status_o.standby      <= (pst_r == sensor_ctl_pkg::PWR_SLEEP);
      status_o.streaming    <= (pst_r == sensor_ctl_pkg::PWR_STREAM) ||
                               (pst_r == sensor_ctl_pkg::PWR_DRAIN);
      status_o.synth_enable <= (pst_r != sensor_ctl_pkg::PWR_SLEEP);
      status_o.synth_locked <= (pst_r != sensor_ctl_pkg::PWR_SLEEP) &&
                               (pst_r != sensor_ctl_pkg::PWR_LOCK);
      status_o.frame_start  <= first_frame_r;
    end
  end

  generate
    for (gi = 1; gi <= 21; gi++) begin : g_cfg
      assign synth_cfg_o[8*gi-1 -: 8] = regs_r[gi];
    end
  endgenerate

endmodule

// File: rtl/sensor_ctl_params.svh
`ifndef SENSOR_CTL_PARAMS_SVH
`define SENSOR_CTL_PARAMS_SVH

// Register sub-addresses.
`define ADDR_STREAM_MODE        16'h0100
`define ADDR_MAIN_INPUT_DIV     16'h0300
`define ADDR_MAIN_MULT_HIGH     16'h0301
`define ADDR_MAIN_MULT_LOW      16'h0302
`define ADDR_MAIN_M_DIV         16'h0303
`define ADDR_MAIN_SERIAL_DIV    16'h0304
`define ADDR_MAIN_SP_DIV        16'h0305
`define ADDR_MAIN_S_DIV         16'h0306
`define ADDR_MAIN_BYPASS        16'h0308
`define ADDR_MAIN_CHARGE_PUMP   16'h0309
`define ADDR_MAIN_PREDIV_ZERO   16'h030A
`define ADDR_AUX_INPUT_DIV      16'h030B
`define ADDR_AUX_MULT_HIGH      16'h030C
`define ADDR_AUX_MULT_LOW       16'h030D
`define ADDR_AUX_SYS_DIV        16'h030E
`define ADDR_AUX_SYS_PREDIV     16'h030F
`define ADDR_AUX_CHARGE_PUMP    16'h0310
`define ADDR_AUX_PREDIV_ZERO    16'h0311
`define ADDR_AUX_BYP_DAC_DIV    16'h0312
`define ADDR_AUX_MEM_DIV        16'h0313
`define ADDR_MAIN_SYNTH_RESET   16'h031B
`define ADDR_AUX_SYNTH_RESET    16'h031C
`define ADDR_SELECTABLE_ID      16'h3035
`define ADDR_COMMON_ID          16'h3036
`define ADDR_SPARE_ID           16'h3037

// Reset values.
`define RST_STREAM_MODE         8'h00
`define RST_MAIN_MULT_LOW       8'h3C
`define RST_MAIN_SERIAL_DIV     8'h07
`define RST_ONE                 8'h01
`define RST_AUX_MULT_LOW        8'h28
`define RST_AUX_SYS_DIV         8'h02
`define RST_THREE               8'h03
`define RST_ZERO                8'h00
`define RST_SELECTABLE_ID       8'h6C
`define RST_COMMON_ID           8'h42
`define RST_SPARE_ID            8'h00

// Field positions.
`define STREAM_BIT              0
`define SYNTH_RESET_BIT         0

// Timing.
`define CLK_PERIOD_NS           40
`define SYNTH_LOCK_NS           200000
`define FIRST_FRAME_FIXED_NS    10000000
`define SYNTH_LOCK_CYC          (`SYNTH_LOCK_NS / `CLK_PERIOD_NS)
`define FIRST_FRAME_FIXED_CYC   (`FIRST_FRAME_FIXED_NS / `CLK_PERIOD_NS)
`define LINE_CYC_DEFAULT        100
`define REG_COUNT               25

`endif

// File: rtl/sensor_ctl_pkg.sv
package sensor_ctl_pkg;

  typedef enum logic [4:0] {
    BUS_IDLE   = 5'b00001,
    BUS_RX     = 5'b00010,
    BUS_RX_ACK = 5'b00100,
    BUS_TX     = 5'b01000,
    BUS_TX_ACK = 5'b10000
  } bus_state_t;

  typedef enum logic [5:0] {
    PWR_SLEEP  = 6'b000001,
    PWR_LOCK   = 6'b000010,
    PWR_FIXED  = 6'b000100,
    PWR_EXPO   = 6'b001000,
    PWR_STREAM = 6'b010000,
    PWR_DRAIN  = 6'b100000
  } pwr_state_t;

  typedef struct packed {
    logic standby;
    logic streaming;
    logic synth_enable;
    logic synth_locked;
    logic frame_start;
  } pwr_status_t;

endpackage

// File: bench/sensor_port_checker_sva.sv
module sensor_port_checker #(
  parameter int unsigned LOCK_CYC  = 8,
  parameter int unsigned FIXED_CYC = 20,
  parameter int unsigned LINE_CYC  = 4
) (
  input wire logic                        sys_clk_i,
  input wire logic                        rst_n_i,
  input wire logic                        shutdown_pin_n_i,
  input wire logic                        core_supply_good_i,
  input wire logic                        scl_i,
  input wire logic                        sda_oe_n_o,
  input wire logic                        frame_active_i,
  input wire logic [15:0]                 exposure_lines_i,
  input wire sensor_ctl_pkg::pwr_status_t status_o,
  input wire logic [167:0]                synth_cfg_o
);
  timeunit 1ns / 1ps;
  localparam logic [167:0] SYNTH_DEF = 168'h0000000300010302280000000100010107003C0000;

  logic        hold_w;
  logic        seen_r;
  logic [31:0] lock_cnt_r;
  logic [31:0] frame_cnt_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // A synthesizer held in reset is not yet enabled, so its wait does not count.
  assign hold_w = synth_cfg_o[152] || synth_cfg_o[160];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt_r <= '0;
    end else if (status_o.synth_enable && !status_o.synth_locked && !hold_w) begin
      lock_cnt_r <= lock_cnt_r + 32'h1;
    end else begin
      lock_cnt_r <= '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_r <= 1'b0;
    end else if (!status_o.synth_enable) begin
      seen_r <= 1'b0;
    end else if (status_o.frame_start) begin
      seen_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_cnt_r <= '0;
    end else if (status_o.synth_enable && !seen_r && !status_o.frame_start && !hold_w) begin
      frame_cnt_r <= frame_cnt_r + 32'h1;
    end else begin
      frame_cnt_r <= '0;
    end
  end

  sequence s_shut_held;
    (!shutdown_pin_n_i) [*5];
  endsequence

  sequence s_frame_held;
    (frame_active_i && shutdown_pin_n_i && core_supply_good_i) [*4] ##0 status_o.streaming;
  endsequence

  a_shutdown_quiet: assert property (s_shut_held |-> sda_oe_n_o)
    else $error("data line driven while shut down");
  a_shutdown_defaults: assert property (s_shut_held
    |-> synth_cfg_o == SYNTH_DEF && status_o == 5'h10)
    else $error("state not at defaults while shut down");
  a_supply_reset: assert property ((!core_supply_good_i) [*5] |-> synth_cfg_o == SYNTH_DEF)
    else $error("state not at defaults without core supply");
  a_standby_idle: assert property (status_o.standby
    |-> !status_o.synth_enable && !status_o.frame_start)
    else $error("activity while in standby");
  a_lock_bound: assert property (lock_cnt_r <= LOCK_CYC + 32'h3)
    else $error("synthesizer lock too late");
  a_first_frame: assert property (frame_cnt_r <= LOCK_CYC + FIXED_CYC
    + exposure_lines_i * LINE_CYC + 6)
    else $error("first frame start too late");
  a_frame_pulse: assert property ($rose(status_o.frame_start) |=> !status_o.frame_start)
    else $error("frame start pulse too long");
  a_frame_finish: assert property (s_frame_held |=> !status_o.standby)
    else $error("standby entered during a frame");
  a_bit_timing: assert property ($changed(sda_oe_n_o) && $past(shutdown_pin_n_i, 5)
    && shutdown_pin_n_i
    |-> !($past(scl_i, 2) && $past(scl_i, 3) && $past(scl_i, 4) && $past(scl_i, 5)))
    else $error("data line changed while serial clock high");
endmodule

bind sensor_control_port_standby sensor_port_checker #(
  .LOCK_CYC(LOCK_CYC), .FIXED_CYC(FIXED_CYC), .LINE_CYC(LINE_CYC)
) sensor_port_checker_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .shutdown_pin_n_i(shutdown_pin_n_i),
  .core_supply_good_i(core_supply_good_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .frame_active_i(frame_active_i), .exposure_lines_i(exposure_lines_i),
  .status_o(status_o), .synth_cfg_o(synth_cfg_o)
);

// File: bench/host_bus_model.sv
module host_bus_model (
  input  wire logic clk_i,
  input  wire logic sda_oe_n_i,
  output logic      scl_o,
  output wire logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drv_low_r;

  // Both parties are open drain; the pull-up wins when nobody pulls low.
  assign sda_o = !drv_low_r && sda_oe_n_i;

  initial begin
    scl_o = 1'b1;
    drv_low_r = 1'b0;
  end

  task automatic q();
    repeat (2) @(negedge clk_i);
  endtask

  task automatic start();
    drv_low_r = 1'b0;
    q();
    q();
    scl_o = 1'b1;
    q();
    drv_low_r = 1'b1;
    q();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    drv_low_r = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    drv_low_r = 1'b0;
    q();
  endtask

  // Sampling mid-high leaves room for the device's synchroniser delay.
  task automatic bit_io(input logic b, output logic r);
    q();
    drv_low_r = !b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_o;
    q();
    scl_o = 1'b0;
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// File: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LOCK_CYC  = 8;
  localparam int unsigned FIXED_CYC = 20;
  localparam int unsigned LINE_CYC  = 4;
  localparam logic [167:0] SYNTH_DEF = 168'h0000000300010302280000000100010107003C0000;

  logic                        sys_clk;
  logic                        rst_n;
  logic                        shutdown_n;
  logic                        supply_good;
  logic                        id_pin;
  logic                        frame_active;
  logic [15:0]                 exposure;
  wire logic                   scl;
  wire logic                   sda;
  logic                        sda_oe_n;
  logic                        sda_pad;
  sensor_ctl_pkg::pwr_status_t status;
  logic [167:0]                synth_cfg;
  int                          errors;
  int                          checks;

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  sensor_control_port_standby #(
    .LOCK_CYC(LOCK_CYC), .FIXED_CYC(FIXED_CYC), .LINE_CYC(LINE_CYC)
  ) sensor_control_port_standby_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .shutdown_pin_n_i(shutdown_n),
    .core_supply_good_i(supply_good), .bus_id_select_pin_i(id_pin), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_pad), .sda_oe_n_o(sda_oe_n), .frame_active_i(frame_active),
    .exposure_lines_i(exposure), .status_o(status), .synth_cfg_o(synth_cfg)
  );

  host_bus_model host_bus_model_i (
    .clk_i(sys_clk), .sda_oe_n_i(sda_oe_n || sda_pad), .scl_o(scl), .sda_o(sda)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [167:0] got, input logic [167:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic addr_phase(input logic [7:0] id, input logic [15:0] sub);
    logic ack;
    host_bus_model_i.start();
    host_bus_model_i.tx(id, ack);
    check(ack, 1'b1);
    host_bus_model_i.tx(sub[15:8], ack);
    check(ack, 1'b1);
    host_bus_model_i.tx(sub[7:0], ack);
    check(ack, 1'b1);
  endtask

  task automatic wr(input logic [7:0] id, input logic [15:0] sub, input logic [31:0] data,
                    input int n);
    logic ack;
    addr_phase(id, sub);
    for (int i = 0; i < n; i++) begin
      host_bus_model_i.tx(data[31 - 8 * i -: 8], ack);
      check(ack, 1'b1);
    end
    host_bus_model_i.stop();
  endtask

  task automatic rd(input logic [7:0] id, input logic [15:0] sub, input logic random_loc,
                    input int n, output logic [31:0] got);
    logic       ack;
    logic [7:0] b;
    got = '0;
    if (random_loc) begin
      addr_phase(id, sub);
    end
    host_bus_model_i.start();
    host_bus_model_i.tx(id | 8'h01, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_bus_model_i.rx(i == n - 1, b);
      got = {got[23:0], b};
    end
    host_bus_model_i.stop();
  endtask

  task automatic probe(input logic [7:0] id, input logic exp);
    logic ack;
    host_bus_model_i.start();
    host_bus_model_i.tx(id, ack);
    host_bus_model_i.stop();
    check(ack, exp);
  endtask

  task automatic wait_frame();
    int n;
    n = 0;
    while (status.frame_start !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check(n <= LOCK_CYC + FIXED_CYC + 3 * LINE_CYC + 12, 1'b1);
    if (n >= 400) begin
      print_verdict();
    end
  endtask

  task automatic scn_defaults();
    logic [31:0] got;
    check(synth_cfg, SYNTH_DEF);
    check(status, 5'h10);
    rd(8'h6C, 16'h3036, 1'b1, 1, got);
    check(got, 32'h42);
    rd(8'h42, 16'h3035, 1'b1, 1, got);
    check(got, 32'h6C);
  endtask

  task automatic scn_burst();
    logic [31:0] got;
    wr(8'h6C, 16'h0300, 32'h11223344, 4);
    check(synth_cfg[31:0], 32'h44332211);
    rd(8'h6C, 16'h0301, 1'b1, 2, got);
    check(got, 32'h2233);
    rd(8'h6C, 16'h0000, 1'b0, 1, got);
    check(got, 32'h44);
    // The hole at 0x0307 drops its byte; the pointer still steps over it.
    wr(8'h6C, 16'h0307, 32'h5AA50000, 2);
    rd(8'h6C, 16'h0307, 1'b1, 2, got);
    check(got, 32'h00A5);
    check(synth_cfg[63:56], 8'hA5);
  endtask

  task automatic scn_ids();
    probe(8'h50, 1'b0);
    id_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    probe(8'h6C, 1'b0);
    probe(8'h42, 1'b1);
    id_pin = 1'b0;
    wr(8'h6C, 16'h3035, 32'h5A000000, 1);
    probe(8'h5A, 1'b1);
    probe(8'h6C, 1'b0);
    wr(8'h42, 16'h3036, 32'h44000000, 1);
    probe(8'h44, 1'b1);
    probe(8'h42, 1'b0);
  endtask

  task automatic scn_shutdown();
    repeat (512) @(negedge sys_clk);
    shutdown_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    probe(8'h5A, 1'b0);
    check(synth_cfg, SYNTH_DEF);
    shutdown_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    probe(8'h6C, 1'b1);
    probe(8'h44, 1'b0);
    wr(8'h6C, 16'h0302, 32'h99000000, 1);
    repeat (512) @(negedge sys_clk);
    supply_good = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(synth_cfg, SYNTH_DEF);
    supply_good = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic scn_stream();
    logic [31:0] got;
    wr(8'h6C, 16'h0302, 32'h50000000, 1);
    wr(8'h6C, 16'h0100, 32'h01000000, 1);
    wait_frame();
    frame_active = 1'b1;
    wr(8'h6C, 16'h0100, 32'h00000000, 1);
    repeat (20) @(negedge sys_clk);
    check(status.standby, 1'b0);
    frame_active = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(status.standby, 1'b1);
    rd(8'h6C, 16'h0302, 1'b1, 1, got);
    check(got, 32'h50);
    wr(8'h6C, 16'h0100, 32'h01000000, 1);
    wait_frame();
    wr(8'h6C, 16'h0100, 32'h00000000, 1);
    repeat (4) @(negedge sys_clk);
    check(status.standby, 1'b1);
    check(synth_cfg[23:16], 8'h50);
  endtask

  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    shutdown_n = 1'b1;
    supply_good = 1'b1;
    id_pin = 1'b0;
    frame_active = 1'b0;
    exposure = 16'h0003;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8192) @(negedge sys_clk);
    scn_defaults();
    scn_burst();
    scn_ids();
    scn_shutdown();
    scn_stream();
    print_verdict();
  end
endmodule
